// *** rtl/ext_trig_pkg.sv ***
package ext_trig_pkg;
  // register map and field layout of the slave configuration word
  localparam logic [7:0]  SLAVE_MODE_CONFIG_OFS = 8'h08;
  localparam logic [7:0]  COUNT_VALUE_OFS       = 8'h0c;
  localparam logic [31:0] SLAVE_MODE_CONFIG_RST = 32'h00000000;
  localparam logic [15:0] SLAVE_MODE_CONFIG_WMASK = 16'hff80;
  localparam int POL_BIT      = 15;
  localparam int CLKB_BIT     = 14;
  localparam int PSC_LSB      = 12;
  localparam int FLT_LSB      = 8;
  localparam int SYNC_BIT     = 7;
  // dead-time sample clock divider relative to kernel clock
  localparam int DTS_DIV_DEFAULT = 1;
  localparam logic [3:0] TSEL_FORBIDDEN = 4'h8;
endpackage

// *** rtl/ext_trig_cond.sv ***
`timescale 1ns/1ns
// Summary of operation
// (R1) polarity bit 0 takes rising/high as active, 1 takes falling/low.
// (R2) clock mode b enable makes counter advance on each conditioned trigger edge.
// (R3) clock mode b works with restart/pause/event slaves; select 1000 forbidden then.
// (R4) with clock modes a and b both on, conditioned trigger clocks counter.
// (R5) prescale field divides trigger by 1, 2, 4 or 8.
// (R6) conditioned trigger rate must stay at or below kernel clock over four.
// (R7) filter counts equal consecutive samples, accepting a level at filter length.
// (R8) codes 0 off; 1-3 lengths 2,4,8 at kernel; 4-5 lengths 6,8 at half.
// (R9) codes 6-15 lengths 6/8, 6/8, 5/6/8, 5/6/8 at dead-time clock /4,/8,/16,/32.
// (R10) sync start bit makes trigger input the start event for linked timers.
// (R11) software keeps reserved register bits at reset value.
// (R12) trigger synchronised first; filter count restarts when a sample changes.
module ext_trig_cond
  import ext_trig_pkg::*;
#(
  parameter int DTS_DIV = DTS_DIV_DEFAULT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        ext_trigger_in,
  input  wire logic        trigger_input,
  input  wire logic        ext_clock_mode_a_enable,
  output logic             ext_trigger_conditioned,
  output logic [15:0]      count_value,
  output logic             trigger_output
);

  // configuration register and bus state
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;

  // waitrequest is high until the one-cycle acknowledge, so every access takes two cycles
  always_comb begin
    next_cfg      = cfg;
    next_ack      = (read || write) && !ack;
    next_readdata = readdata;
    if ((read || write) && !ack) begin
      next_readdata = 32'h00000000;
      if (read && address == SLAVE_MODE_CONFIG_OFS) begin
        next_readdata = {16'h0000, cfg};
      end else if (read && address == COUNT_VALUE_OFS) begin
        next_readdata = {16'h0000, count_value};
      end
    end
    // a write lands only at the edge where the master sees waitrequest low, i.e. while ack is up
    // reserved bits never store, so they keep reading zero [R11]
    if (write && ack && address == SLAVE_MODE_CONFIG_OFS) begin
      if (byteenable[0]) next_cfg[7:0] = writedata[7:0] & SLAVE_MODE_CONFIG_WMASK[7:0];
      if (byteenable[1]) next_cfg[15:8] = writedata[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg      <= SLAVE_MODE_CONFIG_RST[15:0];
      ack      <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      cfg      <= next_cfg;
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) waitrequest <= 1'b1;
    else     waitrequest <= !next_ack;
  end

  logic       pol;
  logic       clkb;
  logic [1:0] psc;
  logic [3:0] flt;
  logic       sync_en;
  assign pol     = cfg[POL_BIT];
  assign clkb    = cfg[CLKB_BIT];
  assign psc     = cfg[PSC_LSB +: 2];
  assign flt     = cfg[FLT_LSB +: 4];
  assign sync_en = cfg[SYNC_BIT];

  // three-stage synchroniser; a change counts once stages two and three agree [R12]
  logic [2:0] sync_q;
  logic       settled;
  logic       next_settled;
  always_comb begin
    next_settled = (sync_q[1] == sync_q[2]) ? sync_q[1] : settled;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q  <= 3'b000;
      settled <= 1'b0;
    end else begin
      sync_q  <= {sync_q[1:0], ext_trigger_in};
      settled <= next_settled;
    end
  end

  // polarity folds active-low onto active-high [R1]
  logic active_lvl;
  assign active_lvl = settled ^ pol;

  // prescaler: count active rising edges, pass one output pulse per 2^psc edges [R5]
  logic       act_d;
  logic [2:0] psc_cnt;
  logic [2:0] next_psc_cnt;
  logic       psc_out;
  logic       next_psc_out;
  always_comb begin
    next_psc_cnt = psc_cnt;
    next_psc_out = psc_out;
    if (psc == 2'b00) begin
      next_psc_out = active_lvl;                                   // [R5]
      next_psc_cnt = 3'h0;
    end else if (active_lvl && !act_d) begin
      next_psc_cnt = psc_cnt + 3'h1;
      if (psc_cnt == 3'(((1 << psc) >> 1) - 1)) next_psc_out = 1'b1;   // [R5]
      if (psc_cnt == 3'((1 << psc) - 1)) begin
        next_psc_out = 1'b0;
        next_psc_cnt = 3'h0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_d   <= 1'b0;
      psc_cnt <= 3'h0;
      psc_out <= 1'b0;
    end else begin
      act_d   <= active_lvl;
      psc_cnt <= next_psc_cnt;
      psc_out <= next_psc_out;
    end
  end

  // filter length per code [R8] [R9]
  function automatic logic [3:0] flt_len(input logic [3:0] code);
    case (code)
      4'h1:                      flt_len = 4'h2;
      4'h2:                      flt_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: flt_len = 4'h6;
      4'ha, 4'hd:                flt_len = 4'h5;
      default:                   flt_len = 4'h8;
    endcase
  endfunction

  // sample divider in kernel cycles: 1, 2, or dead-time clock over 4..32 [R8] [R9]
  function automatic logic [15:0] flt_div(input logic [3:0] code);
    case (code)
      4'h4, 4'h5: flt_div = 16'h2;
      4'h6, 4'h7: flt_div = 16'(4 * DTS_DIV);
      4'h8, 4'h9: flt_div = 16'(8 * DTS_DIV);
      4'ha, 4'hb, 4'hc: flt_div = 16'(16 * DTS_DIV);
      4'hd, 4'he, 4'hf: flt_div = 16'(32 * DTS_DIV);
      default:    flt_div = 16'h1;
    endcase
  endfunction

  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        samp_en;
  logic        last_samp;
  logic        next_last_samp;
  logic [3:0]  run_len;
  logic [3:0]  next_run_len;
  logic        filt;
  logic        next_filt;
  // sample enable comes from the divider: one cycle in flt_div(flt), every cycle when that is 1
  always_comb begin
    samp_en        = (div_cnt >= flt_div(flt) - 16'h1);
    next_div_cnt   = samp_en ? 16'h0 : div_cnt + 16'h1;
    next_last_samp = last_samp;
    next_run_len   = run_len;
    next_filt      = filt;
    if (flt == 4'h0) begin
      next_filt    = psc_out;                                      // [R8]
      next_run_len = 4'h0;
    end else if (samp_en) begin
      next_last_samp = psc_out;
      if (psc_out != last_samp) begin
        next_run_len = 4'h1;                                       // [R12]
      end else if (run_len < flt_len(flt)) begin
        next_run_len = run_len + 4'h1;                             // [R7]
      end
      if (psc_out == last_samp && run_len + 4'h1 >= flt_len(flt)) next_filt = psc_out;  // [R7]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt   <= 16'h0;
      last_samp <= 1'b0;
      run_len   <= 4'h0;
      filt      <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      last_samp <= next_last_samp;
      run_len   <= next_run_len;
      filt      <= next_filt;
    end
  end

  // counter: advances on conditioned rising edge when mode b, or a together with b [R2] [R4]
  logic trig_in_q;
  logic trig_in_d;
  logic started;
  logic next_started;
  logic [15:0] next_count;
  logic next_trig_out;
  logic filt_d;
  always_comb begin
    next_started  = started;
    next_trig_out = 1'b0;
    next_count    = count_value;
    // when sync start is on, counting waits for the trigger input edge [R10]
    // started drops while sync start is off, so a later enable waits for a fresh start edge
    if (!sync_en) next_started = 1'b0;
    else if (trig_in_q && !trig_in_d && !started) begin
      next_started  = 1'b1;
      next_trig_out = 1'b1;                                        // [R10]
    end
    // mode a alone is kept outside; b wins the clock choice when both are set [R4]
    if (clkb && (started || !sync_en) && filt && !filt_d) next_count = count_value + 16'h1;  // [R2] [R3]
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_in_q <= 1'b0;
      trig_in_d <= 1'b0;
      started   <= 1'b0;
      filt_d    <= 1'b0;
      count_value <= 16'h0;
      trigger_output <= 1'b0;
      ext_trigger_conditioned <= 1'b0;
    end else begin
      trig_in_q <= trigger_input;
      trig_in_d <= trig_in_q;
      started   <= next_started;
      filt_d    <= filt;
      count_value <= next_count;
      trigger_output <= next_trig_out;
      ext_trigger_conditioned <= filt;
    end
  end

  logic unused_a;
  assign unused_a = ext_clock_mode_a_enable;

  chk_count_step: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    (count_value != $past(count_value)) |-> (count_value == $past(count_value) + 16'h1))
    else $error("counter moved by other than one");
  chk_count_off: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    !$past(clkb) |-> $stable(count_value)) else $error("counter moved with mode b off");
  chk_filter_off: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    (flt == 4'h0 && $past(flt) == 4'h0) |-> filt == $past(psc_out)) else $error("filter not bypassed");
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
    cfg[6:0] == 7'h00) else $error("reserved bits stored");
  chk_no_psc: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
    (psc == 2'b00 && $past(psc) == 2'b00) |-> psc_out == $past(active_lvl)) else $error("prescaler not bypassed");
  chk_run_restart: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
    (flt != 4'h0 && samp_en && psc_out != last_samp) |=> run_len == 4'h1) else $error("filter run not restarted");
  chk_sync_wait: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    (sync_en && !started) |=> $stable(count_value)) else $error("counted before sync start");
  chk_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
    ((read || write) && waitrequest && !ack) |=> !waitrequest) else $error("bus answer late");
endmodule

// *** verif/trig_source.sv ***
`timescale 1ns/1ns
// far side: the trigger pin source and the start line of a linked timer
module trig_source (
  output logic ext_trigger_in,
  output logic trigger_input,
  input  wire logic clk_sys
);
  logic idle = 1'b0;
  initial begin
    ext_trigger_in = 1'b0;
    trigger_input = 1'b0;
  end
  // n pulses away from the idle level; callers keep hi+lo >= 4 so edges never outrun a quarter of the clock
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      ext_trigger_in <= ~idle;
      repeat (hi) @(posedge clk_sys);
      ext_trigger_in <= idle;
      repeat (lo) @(posedge clk_sys);
    end
  endtask
  task automatic set_idle(input logic v);
    idle = v;
    ext_trigger_in <= v;
  endtask
  // one-cycle start strobe from the linked timer
  task automatic start_strobe();
    trigger_input <= 1'b1;
    @(posedge clk_sys);
    trigger_input <= 1'b0;
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import ext_trig_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        mode_a = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest, ext_trigger_in, trigger_input, ext_trigger_conditioned, trigger_output;
  logic [15:0] count_value;
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          tests_run = 0;
  int          starts = 0;
  int          lens[16] = '{0, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int          divs[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
  always #10 clk_sys = ~clk_sys;
  ext_trig_cond #(.DTS_DIV(1)) dut (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .ext_trigger_in(ext_trigger_in), .trigger_input(trigger_input),
    .ext_clock_mode_a_enable(mode_a), .ext_trigger_conditioned(ext_trigger_conditioned),
    .count_value(count_value), .trigger_output(trigger_output));
  trig_source src (.ext_trigger_in(ext_trigger_in), .trigger_input(trigger_input), .clk_sys(clk_sys));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // answer watcher: each completed read is judged against the oldest note
  always @(posedge clk_sys) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) check(readdata, exp_q.pop_front());
    if (trigger_output === 1'b1) starts++;
  end
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // reserved bits always written as zero; the select field lives elsewhere, so 1000 is never set
  task automatic cfg(input logic p, input logic b, input logic [1:0] s, input logic [3:0] f, input logic y);
    bus(1'b1, SLAVE_MODE_CONFIG_OFS, {16'h0, p, b, s, f, y, 7'h0});
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    int n;
    int w;
    void'($urandom(32'h3aad));
    do_reset();
    rd(SLAVE_MODE_CONFIG_OFS, SLAVE_MODE_CONFIG_RST);
    bus(1'b1, SLAVE_MODE_CONFIG_OFS, 32'h0000ff80);
    rd(SLAVE_MODE_CONFIG_OFS, 32'h0000ff80);
    bus(1'b1, COUNT_VALUE_OFS, 32'h1234);
    rd(COUNT_VALUE_OFS, 32'h0);
    rd(8'h40, 32'h0);
    $display("registers done");
    for (int p = 0; p < 5; p++) begin
      do_reset();
      mode_a <= (p == 3);
      n = 8 * $urandom_range(1, 4);
      cfg(1'b0, p < 4, p[1:0], 4'h0, 1'b0);
      src.pulses(n, 2, 2);
      repeat (8) @(posedge clk_sys);
      rd(COUNT_VALUE_OFS, (p < 4) ? n >> p : 0);
    end
    mode_a <= 1'b0;
    $display("prescaler done");
    do_reset();
    cfg(1'b1, 1'b0, 2'd0, 4'h0, 1'b0);
    repeat (8) @(posedge clk_sys);
    check({31'h0, ext_trigger_conditioned}, 32'h1);
    src.set_idle(1'b1);
    repeat (8) @(posedge clk_sys);
    check({31'h0, ext_trigger_conditioned}, 32'h0);
    cfg(1'b1, 1'b1, 2'd0, 4'h0, 1'b0);
    src.pulses(5, 2, 2);
    repeat (8) @(posedge clk_sys);
    rd(COUNT_VALUE_OFS, 32'd5);
    do_reset();
    src.set_idle(1'b0);
    $display("polarity done");
    for (int c = 1; c < 16; c++) begin
      do_reset();
      cfg(1'b0, 1'b1, 2'd0, c[3:0], 1'b0);
      w = (lens[c] + 2) * divs[c];
      repeat (w) @(posedge clk_sys);
      src.pulses(1, (lens[c] - 1) * divs[c], w);
      src.pulses(1, w, w);
      rd(COUNT_VALUE_OFS, 32'd1);
    end
    $display("filter done");
    do_reset();
    cfg(1'b0, 1'b1, 2'd0, 4'h0, 1'b1);
    src.pulses(4, 2, 2);
    rd(COUNT_VALUE_OFS, 32'd0);
    starts = 0;
    src.start_strobe();
    repeat (4) @(posedge clk_sys);
    check(starts, 32'd1);
    src.pulses(4, 2, 2);
    repeat (8) @(posedge clk_sys);
    rd(COUNT_VALUE_OFS, 32'd4);
    check({16'h0, count_value}, 32'd4);
    $display("sync start done");
    repeat (4) @(posedge clk_sys);
    check(exp_q.size(), 32'd0);
    tally_and_finish();
  end
  // watchdog sized well past the longest filter sweep
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
